// ### sc_tx_regs.svh
// Register indices, bit positions, reset values and timing defaults
`ifndef SC_TX_REGS_SVH
`define SC_TX_REGS_SVH
`define APB_AW       18
`define IDX_CTRL     16'hFE06
`define IDX_DATA     16'hFE07
`define IDX_CFG      16'hFE40
`define B_DIRECT     7
`define B_FULL       5
`define B_EMPTY      4
`define B_UNDR       3
`define B_MARK       2
`define B_DIR        1
`define B_BRK        0
`define C_T1         0
`define C_CHK        1
`define C_SYNC       2
`define C_IO         3
`define CTRL_RST     8'h00
`define CFG_RST      8'h00
`define DATA_RST     8'h00
`define ETU_DEF      16'h0174
`define FRAME_LAST   4'h9
`define GUARD_LAST   4'h1
`define DEPTH_DEF    4
`endif

// ### sc_tx_pkg.sv
// Types shared by the smart card transmit block
`default_nettype none
package sc_tx_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SEND  = 2'b01,
        ST_GUARD = 2'b10
    } tx_state_t;

    typedef struct packed {
        tx_state_t   st;
        logic [3:0]  bit_idx;
        logic [15:0] etu_cnt;
        logic [9:0]  frame;
        logic        src_chk;
        logic        err_seen;
        logic        lk_q;
        logic        direct;
        logic        marker;
        logic        dir;
        logic        underrun;
        logic        brk;
        logic        t1;
        logic        chk_en;
        logic        sync_mode;
        logic        card_io;
        logic [7:0]  lrc;
        logic        chk_done;
        logic        full_q;
        logic        empty_q;
        logic        evt;
        logic        txm;
        logic        io_oe;
        logic [31:0] prdata;
        logic        slverr;
    } tx_ctl_t;
endpackage : sc_tx_pkg
`default_nettype wire

// ### sc_tx_fifo_if.sv
// Carrier between the transmit control and its byte queue
`default_nettype none
interface sc_tx_fifo_if;
    logic       push;
    logic [7:0] wdata;
    logic       pop;
    logic [7:0] rdata;
    logic       full;
    logic       empty;
    modport ctl_side  (output push, output wdata, output pop, input rdata, input full, input empty);
    modport fifo_side (input push, input wdata, input pop, output rdata, output full, output empty);
endinterface : sc_tx_fifo_if
`default_nettype wire

// ### sc_sync2.sv
// Two-stage synchroniser for signals from outside the pclk domain
`default_nettype none
module sc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t r;
    sync_t s;

    // First stage is read by the second only
    always_comb begin
        s = r;
        s.s1 = d;
        s.s2 = r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    assign q = r.s2;
endmodule : sc_sync2
`default_nettype wire

// ### sc_tx_fifo.sv
// Transmit byte queue held in flip-flops
`default_nettype none
`include "sc_tx_regs.svh"
module sc_tx_fifo
    import sc_tx_pkg::*;
#(
    parameter int DEPTH = `DEPTH_DEF
) (
    input  wire logic pclk,
    input  wire logic presetn,
    sc_tx_fifo_if.fifo_side f
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0]         wp;
        logic [AW-1:0]         rp;
        logic [AW:0]           cnt;
    } fifo_t;
    fifo_t r;
    fifo_t s;
    logic  do_push;
    logic  do_pop;

    // Writes into a full queue are dropped rather than corrupting it
    always_comb begin
        s = r;
        do_push = f.push && (r.cnt != (AW+1)'(DEPTH));
        do_pop  = f.pop && (r.cnt != '0);
        if (do_push) begin
            s.mem[r.wp] = f.wdata;
            s.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
        end
        // Pop moves the pointer only; old bytes stay until overwritten
        if (do_pop) begin
            s.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
        end
        s.cnt = r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    assign f.rdata = r.mem[r.rp];
    assign f.full  = (r.cnt == (AW+1)'(DEPTH));
    assign f.empty = (r.cnt == '0);

    chk_pop_keeps_bytes: assert property (
        @(posedge pclk) disable iff (!presetn)
        (do_pop && !do_push) |=> (r.mem == $past(r.mem)))
        else $error("pop altered stored bytes");
endmodule : sc_tx_fifo
`default_nettype wire

// ### smart_card_tx_control.sv
// Smart card transmit control: APB registers, byte queue, character sender
`default_nettype none
`include "sc_tx_regs.svh"
module smart_card_tx_control
    import sc_tx_pkg::*;
#(
    parameter int          DEPTH    = `DEPTH_DEF,
    parameter logic [15:0] ETU_CLKS = `ETU_DEF
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [`APB_AW-1:0]  paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                link_clk,
    input  wire logic [7:0]          length_counter,
    input  wire logic                io_i,
    output logic                     io_o,
    output logic                     io_oe,
    output logic                     tx_mode_active,
    output logic                     tx_event_irq_src,
    output logic                     tx_error_irq
);
    localparam logic [15:0] ETU_HALF = ETU_CLKS >> 1;

    sc_tx_fifo_if fq ();
    tx_ctl_t      r;
    tx_ctl_t      s;
    logic [1:0]   pins_s;
    logic         lk_s;
    logic         io_s;
    logic         lk_edge;
    logic         setup;
    logic         access;
    logic         hit_ctrl;
    logic         hit_data;
    logic         hit_cfg;
    logic         chk_need;
    logic         empty_flag;
    logic         tx_eff;
    logic         direct_sel;
    logic         eng_pop;
    logic         apb_pop;
    logic         etu_end;
    logic [7:0]   ctrl_rd;
    logic [7:0]   cfg_rd;

    sc_sync2 #(
        .W (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link_clk, io_i}),
        .q       (pins_s)
    );

    sc_tx_fifo #(
        .DEPTH (DEPTH)
    ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (fq.fifo_side)
    );

    assign lk_s = pins_s[1];
    assign io_s = pins_s[0];

    // Address decode on word index; byte lanes below are ignored
    assign hit_ctrl = (paddr[`APB_AW-1:2] == `IDX_CTRL);
    assign hit_data = (paddr[`APB_AW-1:2] == `IDX_DATA);
    assign hit_cfg  = (paddr[`APB_AW-1:2] == `IDX_CFG);
    assign setup    = psel && !penable;
    assign access   = psel && penable;

    assign chk_need = r.t1 && r.chk_en;
    // Marker holds empty low until the last byte, and checksum, are out
    assign empty_flag = fq.empty && (!r.marker ||
                        ((r.st == ST_IDLE) && (!chk_need || r.chk_done)));
    // Marker keeps transmit alive after an early switch to receive
    assign tx_eff = r.dir || (r.marker && !empty_flag);
    assign direct_sel = r.sync_mode && r.direct &&
                        ((length_counter == 8'hFF) || (length_counter == 8'h00));
    assign etu_end = lk_edge && (r.etu_cnt == ETU_CLKS - 16'h0001);

    always_comb begin
        ctrl_rd = `CTRL_RST;
        ctrl_rd[`B_DIRECT] = r.direct;
        ctrl_rd[`B_FULL]   = fq.full;
        ctrl_rd[`B_EMPTY]  = empty_flag;
        ctrl_rd[`B_UNDR]   = r.underrun;
        ctrl_rd[`B_MARK]   = r.marker;
        ctrl_rd[`B_DIR]    = r.dir;
        ctrl_rd[`B_BRK]    = r.brk;
        cfg_rd = `CFG_RST;
        cfg_rd[`C_T1]   = r.t1;
        cfg_rd[`C_CHK]  = r.chk_en;
        cfg_rd[`C_SYNC] = r.sync_mode;
        cfg_rd[`C_IO]   = r.card_io;
    end

    always_comb begin
        s = r;
        eng_pop = 1'b0;
        apb_pop = 1'b0;
        fq.push  = 1'b0;
        fq.wdata = pwdata[7:0];
        lk_edge = lk_s && !r.lk_q;
        s.lk_q = lk_s;

        // Read data is captured in setup so the access edge only clears
        if (setup) begin
            s.slverr = !(hit_ctrl || hit_data || hit_cfg);
            s.prdata = 32'h0000_0000;
            if (!pwrite && hit_ctrl) begin
                s.prdata[7:0] = ctrl_rd;
            end else if (!pwrite && hit_cfg) begin
                s.prdata[7:0] = cfg_rd;
            end else if (!pwrite && hit_data) begin
                s.prdata[7:0] = fq.empty ? `DATA_RST : fq.rdata;
            end
        end

        if (access && pwrite) begin
            if (hit_ctrl) begin
                s.direct = pwdata[`B_DIRECT];
                s.marker = pwdata[`B_MARK];
                if (!pwdata[`B_MARK]) begin
                    s.chk_done = 1'b0;
                end
                if (pwdata[`B_DIR] != r.dir) begin
                    s.dir = pwdata[`B_DIR];
                    s.lrc = 8'h00;
                    s.chk_done = 1'b0;
                end
            end else if (hit_cfg) begin
                s.t1        = pwdata[`C_T1];
                s.chk_en    = pwdata[`C_CHK];
                s.sync_mode = pwdata[`C_SYNC];
                s.card_io   = pwdata[`C_IO];
            end else if (hit_data) begin
                fq.push = 1'b1;
                s.chk_done = 1'b0;
            end
        end

        // Clear only what the read returned, so a new event survives
        if (access && !pwrite && hit_ctrl) begin
            s.underrun = r.underrun && !r.prdata[`B_UNDR];
            s.brk      = r.brk && !r.prdata[`B_BRK];
        end
        if (access && !pwrite && hit_data) begin
            apb_pop = !fq.empty;
        end

        if (lk_edge && (r.st != ST_IDLE)) begin
            s.etu_cnt = etu_end ? 16'h0000 : r.etu_cnt + 16'h0001;
        end

        case (r.st)
            ST_IDLE: begin
                if (tx_eff && !fq.empty) begin
                    eng_pop = 1'b1;
                    s.frame = {^fq.rdata, fq.rdata, 1'b0};
                    // Starts from the restarted sum if direction flips now
                    s.lrc = s.lrc ^ fq.rdata;
                    s.src_chk = 1'b0;
                    s.st = ST_SEND;
                    s.bit_idx = 4'h0;
                    s.etu_cnt = 16'h0000;
                    s.err_seen = 1'b0;
                end else if (tx_eff && r.marker && chk_need && !r.chk_done) begin
                    s.frame = {^r.lrc, r.lrc, 1'b0};
                    s.src_chk = 1'b1;
                    s.st = ST_SEND;
                    s.bit_idx = 4'h0;
                    s.etu_cnt = 16'h0000;
                    s.err_seen = 1'b0;
                end
            end
            ST_SEND: begin
                if (etu_end) begin
                    if (r.bit_idx == `FRAME_LAST) begin
                        s.st = ST_GUARD;
                        s.bit_idx = 4'h0;
                    end else begin
                        s.bit_idx = r.bit_idx + 4'h1;
                    end
                end
            end
            ST_GUARD: begin
                // Card pulls IO low mid guard to flag a parity error
                if (lk_edge && !r.t1 && (r.bit_idx == 4'h0) &&
                    (r.etu_cnt == ETU_HALF) && !io_s) begin
                    s.err_seen = 1'b1;
                end
                if (etu_end) begin
                    if (r.bit_idx != `GUARD_LAST) begin
                        s.bit_idx = r.bit_idx + 4'h1;
                    end else if (r.err_seen) begin
                        s.brk = 1'b1;
                        s.st = ST_SEND;
                        s.bit_idx = 4'h0;
                        s.err_seen = 1'b0;
                    end else begin
                        s.st = ST_IDLE;
                        if (r.src_chk) begin
                            s.chk_done = 1'b1;
                        end else if (fq.empty && !r.marker) begin
                            s.underrun = 1'b1;
                        end
                    end
                end
            end
            default: begin
                s.st = ST_IDLE;
            end
        endcase

        fq.pop = eng_pop || apb_pop;

        s.evt = (fq.full && !r.full_q) || (empty_flag && !r.empty_q);
        s.full_q = fq.full;
        s.empty_q = empty_flag;
        s.txm = tx_eff;

        // Open drain: only a low level is driven
        if (direct_sel) begin
            s.io_oe = !r.card_io;
        end else begin
            s.io_oe = (s.st == ST_SEND) && !s.frame[s.bit_idx];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            // Empty flag idles high, so its edge memory starts high too
            r.empty_q <= 1'b1;
        end else begin
            r <= s;
        end
    end

    assign prdata           = r.prdata;
    assign pslverr          = r.slverr && access;
    assign pready           = 1'b1;
    assign io_o             = 1'b0;
    assign io_oe            = r.io_oe;
    assign tx_mode_active   = r.txm;
    assign tx_event_irq_src = r.evt;
    assign tx_error_irq     = r.underrun || r.brk;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_direct_drive: assert property (
        direct_sel |=> (io_oe == !$past(r.card_io)))
        else $error("direct drive does not follow card io bit");

    chk_full_event: assert property (
        $rose(fq.full) |=> tx_event_irq_src)
        else $error("no transmit event on queue full");

    chk_t1_empty_hold: assert property (
        (r.marker && chk_need && !r.chk_done) |-> !empty_flag)
        else $error("empty flag set before checksum sent");

    chk_t0_empty_hold: assert property (
        (r.marker && (r.st != ST_IDLE)) |-> !empty_flag)
        else $error("empty flag set before last byte done");

    chk_empty_event: assert property (
        $rose(empty_flag) |=> tx_event_irq_src)
        else $error("no transmit event on going empty");

    chk_underrun_set: assert property (
        ((r.st == ST_GUARD) && etu_end && (r.bit_idx == `GUARD_LAST) &&
         !r.err_seen && !r.src_chk && fq.empty && !r.marker) |=> tx_error_irq)
        else $error("underrun not flagged");

    chk_dir_restart: assert property (
        (access && pwrite && hit_ctrl && (pwdata[`B_DIR] != r.dir) && (r.st != ST_IDLE))
        |=> (r.lrc == 8'h00))
        else $error("checksum not restarted on direction change");

    chk_marker_keeps_tx: assert property (
        (r.marker && !empty_flag) |=> tx_mode_active)
        else $error("transmit dropped before completion");

    chk_break_set: assert property (
        ((r.st == ST_GUARD) && etu_end && (r.bit_idx == `GUARD_LAST) && r.err_seen)
        |=> r.brk ##1 tx_error_irq)
        else $error("break not flagged");

    chk_push_lands: assert property (
        (access && pwrite && hit_data && !fq.full) |=> !fq.empty)
        else $error("data write did not enter queue");

    chk_full_readback: assert property (
        (setup && !pwrite && hit_ctrl && fq.full) |=> r.prdata[`B_FULL])
        else $error("full flag not shown while queue full");

    chk_idle_start: assert property (
        ((r.st == ST_IDLE) && tx_eff && !fq.empty) |=> (r.st == ST_SEND))
        else $error("queued byte not started");

    chk_rx_stays_idle: assert property (
        ((r.st == ST_IDLE) && !tx_eff) |=> (r.st == ST_IDLE))
        else $error("engine left idle in receive mode");

    chk_break_resend: assert property (
        ((r.st == ST_GUARD) && etu_end && (r.bit_idx == `GUARD_LAST) && r.err_seen) |=> (r.st == ST_SEND))
        else $error("byte not resent after break");

    chk_read_pops: assert property (
        (access && !pwrite && hit_data && fq.full && !eng_pop) |=> !fq.full)
        else $error("data read did not pop queue");
endmodule : smart_card_tx_control
`default_nettype wire

// ### sc_card_model.sv
// Behavioural smart card on the open-drain IO line
`default_nettype none
module sc_card_model #(
    parameter int ETU = 4
) (
    input  wire logic       link_clk,
    input  wire logic       io_line,
    input  wire logic       break_req,
    output logic            card_oe,
    output logic [7:0]      last_byte,
    output logic [7:0]      char_cnt,
    output logic            parity_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       broke;
    logic [8:0] sh;
    initial begin
        card_oe = 1'b0;
        last_byte = 8'h00;
        char_cnt = 8'h00;
        parity_bad = 1'b0;
        broke = 1'b0;
    end
    always begin
        @(posedge link_clk);
        if (io_line === 1'b0) begin
            // Start seen up to one link edge late, so sample mid-bit
            repeat (ETU / 2) @(posedge link_clk);
            for (int k = 0; k < 9; k++) begin
                repeat (ETU) @(posedge link_clk);
                sh[k] = io_line;
            end
            last_byte = sh[7:0];
            char_cnt = char_cnt + 8'h01;
            if (^sh !== 1'b0) parity_bad = 1'b1;
            if (break_req && !broke) begin
                // Pull across the middle of the first guard time
                repeat (ETU - 1) @(posedge link_clk);
                card_oe = 1'b1;
                repeat (ETU + 1) @(posedge link_clk);
                card_oe = 1'b0;
                broke = 1'b1;
            end
            while (io_line !== 1'b1) @(posedge link_clk);
        end
        if (!break_req) broke = 1'b0;
    end
endmodule : sc_card_model
`default_nettype wire

// ### smart_card_tx_control_test.sv
// Self-checking bench for the smart card transmit control
`default_nettype none
`include "sc_tx_regs.svh"
module smart_card_tx_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] A_CTRL = {`IDX_CTRL, 2'b00};
    localparam logic [17:0] A_DATA = {`IDX_DATA, 2'b00};
    localparam logic [17:0] A_CFG  = {`IDX_CFG, 2'b00};
    localparam logic [17:0] A_BAD  = 18'h3F840;
    logic        pclk, presetn, psel, penable, pwrite, link_clk, pready, pslverr;
    logic        io_o, io_oe, tx_mode_active, tx_event_irq_src, tx_error_irq;
    logic        card_oe, parity_bad, break_req, io_line, e;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  length_counter, last_byte, char_cnt, c0;
    int          num_errors, checks, evt_cnt, e0;

    // Open drain with pull-up: either party may pull low
    assign io_line = (io_oe ? io_o : 1'b1) & ~card_oe;

    smart_card_tx_control #(.DEPTH(2), .ETU_CLKS(16'h0004)) smart_card_tx_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clk(link_clk), .length_counter(length_counter), .io_i(io_line), .io_o(io_o),
        .io_oe(io_oe), .tx_mode_active(tx_mode_active), .tx_event_irq_src(tx_event_irq_src),
        .tx_error_irq(tx_error_irq));
    sc_card_model #(.ETU(4)) sc_card_model_i (
        .link_clk(link_clk), .io_line(io_line), .break_req(break_req), .card_oe(card_oe),
        .last_byte(last_byte), .char_cnt(char_cnt), .parity_bad(parity_bad));

    always #20 pclk = ~pclk;
    initial begin
        link_clk = 1'b0;
        #7;
        forever #160 link_clk = ~link_clk;
    end
    always @(posedge pclk) begin
        if (tx_event_irq_src === 1'b1) evt_cnt <= evt_cnt + 1;
    end

    task automatic close_out();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic expect_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : expect_val
    task automatic expect_bit(input string nm, input logic ex, input logic got);
        checks++;
        if (got !== ex) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", nm, ex, got);
        end
    endtask : expect_bit
    task automatic fail_wait(input string nm);
        num_errors++;
        $display("wrong value %s expected done seen timeout", nm);
        close_out();
    endtask : fail_wait
    // Holds the whole request until pready is sampled high
    task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) fail_wait("pready");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [17:0] a, input logic [7:0] ex);
        apb(1'b0, a, 8'h00);
        expect_val(nm, {24'h000000, ex}, q);
    endtask : rd_chk
    // Polling reads also clear the read-to-clear flags
    task automatic wait_empty();
        int n;
        n = 0;
        q = 32'h00000000;
        while (q[`B_EMPTY] !== 1'b1 && n < 400) begin
            repeat (20) @(posedge pclk);
            apb(1'b0, A_CTRL, 8'h00);
            n++;
        end
        if (q[`B_EMPTY] !== 1'b1) fail_wait("empty flag");
    endtask : wait_empty
    task automatic wait_err();
        int n;
        n = 0;
        while (tx_error_irq !== 1'b1 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (tx_error_irq !== 1'b1) fail_wait("error irq");
    endtask : wait_err

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
        length_counter = 8'h05;
        break_req = 1'b0;
        num_errors = 0;
        checks = 0;
        evt_cnt = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl reset", A_CTRL, 8'h10);
        rd_chk("cfg reset", A_CFG, 8'h00);
        apb(1'b0, A_BAD, 8'h00);
        expect_bit("unmapped err", 1'b1, e);
        expect_val("unmapped data", 32'h00000000, q);
        // Receive mode: queue fills and is drained by reads
        e0 = evt_cnt;
        c0 = char_cnt;
        wr(A_DATA, 8'h11);
        wr(A_DATA, 8'h22);
        rd_chk("full", A_CTRL, 8'h20);
        expect_val("full event", 32'h1, evt_cnt - e0);
        rd_chk("pop a", A_DATA, 8'h11);
        rd_chk("pop b", A_DATA, 8'h22);
        rd_chk("emptied", A_CTRL, 8'h10);
        expect_val("empty event", 32'h2, evt_cnt - e0);
        expect_val("no send rx", {24'h0, c0}, {24'h0, char_cnt});
        // T=0 with end marker, direction dropped early
        wr(A_DATA, 8'hA5);
        wr(A_DATA, 8'h3C);
        wr(A_CTRL, 8'h06);
        wr(A_CTRL, 8'h04);
        // Let the cleared direction bit reach the mode output first
        repeat (2) @(posedge pclk);
        expect_bit("tx mode held", 1'b1, tx_mode_active);
        wait_empty();
        expect_val("t0 chars", 32'h2, {24'h0, char_cnt - c0});
        expect_val("t0 byte", 32'h3C, {24'h0, last_byte});
        rd_chk("t0 done", A_CTRL, 8'h14);
        expect_bit("tx mode off", 1'b0, tx_mode_active);
        // Underrun: marker clear, queue runs dry
        wr(A_CTRL, 8'h02);
        wr(A_DATA, 8'h77);
        wait_err();
        rd_chk("underrun", A_CTRL, 8'h1A);
        rd_chk("underrun clr", A_CTRL, 8'h12);
        expect_bit("err irq low", 1'b0, tx_error_irq);
        // T=1 with checksum appended
        wr(A_CFG, 8'h03);
        wr(A_CTRL, 8'h00);
        c0 = char_cnt;
        wr(A_DATA, 8'h12);
        wr(A_DATA, 8'h34);
        wr(A_CTRL, 8'h06);
        wait_empty();
        expect_val("t1 chars", 32'h3, {24'h0, char_cnt - c0});
        expect_val("lrc", 32'h26, {24'h0, last_byte});
        expect_bit("parity", 1'b0, parity_bad);
        // Card signals a break on the first character
        wr(A_CFG, 8'h00);
        wr(A_CTRL, 8'h00);
        wr(A_DATA, 8'h5A);
        c0 = char_cnt;
        break_req <= 1'b1;
        wr(A_CTRL, 8'h06);
        wait_err();
        apb(1'b0, A_CTRL, 8'h00);
        expect_bit("break flag", 1'b1, q[`B_BRK]);
        wait_empty();
        break_req <= 1'b0;
        expect_val("resent", 32'h2, {24'h0, char_cnt - c0});
        expect_val("resent byte", 32'h5A, {24'h0, last_byte});
        rd_chk("break clr", A_CTRL, 8'h16);
        // Direct pin drive in sync mode
        wr(A_CTRL, 8'h00);
        wr(A_CFG, 8'h04);
        wr(A_CTRL, 8'h80);
        rd_chk("direct bit", A_CTRL, 8'h90);
        length_counter <= 8'hFF;
        repeat (4) @(posedge pclk);
        expect_bit("pin low max", 1'b1, io_oe);
        length_counter <= 8'h05;
        repeat (4) @(posedge pclk);
        expect_bit("counter mid", 1'b0, io_oe);
        length_counter <= 8'h00;
        repeat (4) @(posedge pclk);
        expect_bit("pin low zero", 1'b1, io_oe);
        wr(A_CFG, 8'h0C);
        repeat (4) @(posedge pclk);
        expect_bit("pin high", 1'b0, io_oe);
        close_out();
    end
endmodule : smart_card_tx_control_test
`default_nettype wire
